// file: logic/ruc_config_ctrl.sv
// Remote and local update configuration control with a Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Remote mode power-up loads the image held at page zero.
// - Factory logic writes the control register with the next application page.
// - Factory logic chooses watchdog enable and timeout for the next application.
// - Watchdog expiry records the cause in status and reloads the factory image.
// - Watchdog is held off while the factory image is active.
// - Remote-mode application load failure records the cause and reloads the factory image.
// - After reading status, factory logic selects the next page to load.
// - Error-free application load enters user mode and runs it.
// - Page selection covers up to seven application images.
// - Local mode loads its single application at power-up without the factory image.
// - Devices chain by wiring chain enable out to the next chain enable in.
// - User pins tri-state until initialization resets and enables them.
module ruc_config_ctrl
    import ruc_pkg::*;
#(
    parameter logic [PAGE_W-1:0] LOCAL_PAGE  = 3'h1,
    parameter int                WD_PRESCALE = 1024
)
(
    input  wire logic              ref_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              chain_enable_in_n_i,
    output logic                   chain_enable_out_n_o,
    input  wire logic              local_mode_i,
    input  wire logic              load_done_i,
    input  wire logic              load_err_i,
    output logic                   load_req_o,
    output logic      [PAGE_W-1:0] load_page_o,
    output logic                   user_io_oe_n_o,
    output logic                   user_rst_o,
    output logic                   user_mode_o,
    output logic                   app_active_o
);
    localparam int USER_DLY = INIT_CYCLES + 1;
    localparam int IW       = $clog2(INIT_CYCLES + 1);

    if (INIT_CYCLES < 1 || LOCAL_PAGE == FACTORY_PAGE)
    begin : g_chk
        $error("Local page must differ from the factory page.");
    end

    ruc_state_e        state;
    logic [3:0]        meta;
    logic [3:0]        sync;
    logic              ce_s;
    logic              local_s;
    logic              done_s;
    logic              err_s;
    logic              local_mode;
    logic [PAGE_W-1:0] cur_page;
    logic [PAGE_W-1:0] next_page;
    logic              wd_en;
    logic [TO_W-1:0]   wd_timeout;
    logic              wd_arm;
    logic [TO_W-1:0]   wd_limit;
    logic [1:0]        cause;
    logic [PAGE_W-1:0] failed_page;
    logic [IW-1:0]     init_cnt;
    logic              wd_expire;
    logic              wd_run;
    logic              wb_req;
    logic              wr;
    logic              reconf_req;
    logic              kick;
    logic              ev_load_err;
    logic              ev_wdog;
    logic              loading_app;

    // Pins from the memory and the chain pass two flip-flops first.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            meta <= 4'h8;
            sync <= 4'h8;
        end
        else
        begin
            meta <= {chain_enable_in_n_i, local_mode_i, load_done_i, load_err_i};
            sync <= meta;
        end
    end

    assign ce_s    = ~sync[3];
    assign local_s = sync[2];
    assign done_s  = sync[1];
    assign err_s   = sync[0];

    assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr         = wb_req & wb_we_i;
    assign reconf_req = wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[CMD_RECONF_BIT];
    assign kick       = wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[CMD_KICK_BIT];

    assign loading_app = !local_mode && cur_page != FACTORY_PAGE;
    assign ev_load_err = state == ST_LOAD && err_s && loading_app;
    assign ev_wdog     = state == ST_USER && wd_expire;
    assign wd_run      = state == ST_USER && app_active_o && wd_arm;

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_req && !wb_we_i)
        begin
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
                ADR_CTRL:
                begin
                    wb_dat_o[CTRL_PAGE_LSB +: PAGE_W] <= next_page;
                    wb_dat_o[CTRL_WDEN_BIT]           <= wd_en;
                    wb_dat_o[CTRL_TO_LSB +: TO_W]     <= wd_timeout;
                end
                ADR_STATUS:
                begin
                    wb_dat_o[STAT_CAUSE_LSB +: 2]        <= cause;
                    wb_dat_o[STAT_PAGE_LSB +: PAGE_W]    <= cur_page;
                    wb_dat_o[STAT_APP_BIT]               <= app_active_o;
                    wb_dat_o[STAT_LOCAL_BIT]             <= local_mode;
                    wb_dat_o[STAT_FAILED_LSB +: PAGE_W]  <= failed_page;
                end
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Control register: next page and watchdog choice for the next application.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            next_page  <= NEXT_PAGE_RST;
            wd_en      <= 1'b0;
            wd_timeout <= WD_TO_RST;
        end
        else if (wr && wb_adr_i == ADR_CTRL)
        begin
            if (wb_sel_i[0])
            begin
                next_page       <= wb_dat_i[CTRL_PAGE_LSB +: PAGE_W];
                wd_en           <= wb_dat_i[CTRL_WDEN_BIT];
                wd_timeout[3:0] <= wb_dat_i[CTRL_TO_LSB +: 4];
            end
            if (wb_sel_i[1])
                wd_timeout[TO_W-1:4] <= wb_dat_i[CTRL_TO_LSB + 4 +: TO_W - 4];
        end
    end

    // Cause is sticky; a hardware event wins over a software clear.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            cause       <= CAUSE_NONE;
            failed_page <= FACTORY_PAGE;
        end
        else if (ev_load_err)
        begin
            cause       <= CAUSE_LOAD_ERR;
            failed_page <= cur_page;
        end
        else if (ev_wdog)
        begin
            cause       <= CAUSE_WDOG;
            failed_page <= cur_page;
        end
        else if (wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] && wb_dat_i[STAT_CLEAR_BIT])
            cause <= CAUSE_NONE;
    end

    ruc_watchdog #(
        .TW  (TO_W),
        .PRE (WD_PRESCALE)
    ) u_wdog (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (wd_run),
        .kick_i    (kick),
        .limit_i   (wd_limit),
        .expire_o  (wd_expire)
    );

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            state                <= ST_WAIT_CE;
            local_mode           <= 1'b0;
            cur_page             <= FACTORY_PAGE;
            wd_arm               <= 1'b0;
            wd_limit             <= WD_TO_RST;
            init_cnt             <= '0;
            load_req_o           <= 1'b0;
            load_page_o          <= FACTORY_PAGE;
            user_io_oe_n_o       <= 1'b1;
            user_rst_o           <= 1'b0;
            user_mode_o          <= 1'b0;
            app_active_o         <= 1'b0;
            chain_enable_out_n_o <= 1'b1;
        end
        else
        begin
            case (state)
                ST_WAIT_CE:
                    if (ce_s)
                    begin
                        local_mode <= local_s;
                        cur_page   <= local_s ? LOCAL_PAGE : FACTORY_PAGE;
                        state      <= ST_ARM;
                    end
                ST_ARM:
                    if (!done_s && !err_s)
                    begin
                        load_req_o  <= 1'b1;
                        load_page_o <= cur_page;
                        state       <= ST_LOAD;
                    end
                ST_LOAD:
                    if (err_s)
                    begin
                        load_req_o <= 1'b0;
                        state      <= ST_ARM;
                        if (loading_app)
                        begin
                            cur_page <= FACTORY_PAGE;
                            wd_arm   <= 1'b0;
                        end
                    end
                    else if (done_s)
                    begin
                        load_req_o <= 1'b0;
                        user_rst_o <= 1'b1;
                        init_cnt   <= IW'(INIT_CYCLES - 1);
                        state      <= ST_INIT;
                    end
                ST_INIT:
                    if (init_cnt == '0)
                    begin
                        user_rst_o           <= 1'b0;
                        user_io_oe_n_o       <= 1'b0;
                        user_mode_o          <= 1'b1;
                        app_active_o         <= local_mode || cur_page != FACTORY_PAGE;
                        chain_enable_out_n_o <= 1'b0;
                        state                <= ST_USER;
                    end
                    else
                        init_cnt <= init_cnt - 1'b1;
                ST_USER:
                    if (ev_wdog || reconf_req)
                    begin
                        user_io_oe_n_o <= 1'b1;
                        user_mode_o    <= 1'b0;
                        app_active_o   <= 1'b0;
                        state          <= ST_ARM;
                        if (local_mode)
                            cur_page <= LOCAL_PAGE;
                        else if (ev_wdog || app_active_o)
                        begin
                            cur_page <= FACTORY_PAGE;
                            wd_arm   <= 1'b0;
                        end
                        else
                        begin
                            cur_page <= next_page;
                            wd_arm   <= wd_en;
                            wd_limit <= wd_timeout;
                        end
                    end
                default: state <= ST_WAIT_CE;
            endcase
        end
    end

    factory_boot_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state == ST_WAIT_CE && ce_s && !local_s) |=> (state == ST_ARM && cur_page == FACTORY_PAGE))
        else $error("Remote power-up did not select the factory page.");
    local_boot_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state == ST_WAIT_CE && ce_s && local_s) |=> (cur_page == LOCAL_PAGE && local_mode))
        else $error("Local power-up did not select the local page.");
    page_select_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state == ST_USER && reconf_req && !app_active_o && !local_mode && !wd_expire)
            |=> (cur_page == $past(next_page) && wd_arm == $past(wd_en)))
        else $error("Factory reconfiguration did not take the selected page.");
    wd_factory_off_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state == ST_USER && !app_active_o) |-> (!wd_run && !wd_expire))
        else $error("Watchdog ran under the factory image.");
    wd_fallback_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (ev_wdog && !local_mode) |=> (cause == CAUSE_WDOG && cur_page == FACTORY_PAGE
            && state == ST_ARM))
        else $error("Watchdog expiry did not record and fall back.");
    load_err_fallback_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ev_load_err |=> (cause == CAUSE_LOAD_ERR && cur_page == FACTORY_PAGE && !load_req_o))
        else $error("Load error did not record and fall back.");
    user_entry_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state == ST_LOAD && done_s && !err_s) |-> ##USER_DLY (user_mode_o && state == ST_USER))
        else $error("Successful load did not reach user mode in time.");
    io_tristate_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (state != ST_USER) |-> (user_io_oe_n_o && !user_mode_o))
        else $error("User pins enabled outside user mode.");
    chain_pass_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        user_mode_o |-> !chain_enable_out_n_o)
        else $error("Chain enable not passed on in user mode.");
    app_boot_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(app_active_o));
    wd_timeout_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) ev_wdog);
    load_err_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) ev_load_err);
    local_boot_c: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        user_mode_o && local_mode);
endmodule // ruc_config_ctrl
`default_nettype wire

// file: logic/ruc_watchdog.sv
// User watchdog: prescaled down counter reloaded on every kick.
`timescale 1ns/1ps
`default_nettype none
module ruc_watchdog
    import ruc_pkg::*;
#(
    parameter int TW  = 12,
    parameter int PRE = 1024
)
(
    input  wire logic          ref_clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          en_i,
    input  wire logic          kick_i,
    input  wire logic [TW-1:0] limit_i,
    output logic               expire_o
);
    localparam int PW = (PRE > 1) ? $clog2(PRE) : 1;

    if (PRE < 2 || TW < 1)
    begin : g_chk
        $error("Watchdog prescale must be at least 2 and width at least 1.");
    end

    logic [PW-1:0] pre;
    logic [TW-1:0] cnt;

    // A kick or a disabled watchdog restarts the full interval.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i || !en_i || kick_i)
        begin
            pre      <= '0;
            cnt      <= limit_i;
            expire_o <= 1'b0;
        end
        else
        begin
            expire_o <= 1'b0;
            if (pre == PW'(PRE - 1))
            begin
                pre <= '0;
                if (cnt == '0)
                    expire_o <= 1'b1;
                else
                    cnt <= cnt - 1'b1;
            end
            else
                pre <= pre + 1'b1;
        end
    end

    kick_reload_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (en_i && kick_i) |=> (cnt == $past(limit_i) && pre == '0))
        else $error("Watchdog kick did not reload the counter.");

    expire_en_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        expire_o |-> ($past(en_i) && $past(cnt) == '0 && !$past(kick_i)))
        else $error("Watchdog expired without running out.");

endmodule // ruc_watchdog
`default_nettype wire

// file: pkg/ruc_pkg.sv
// Constants, register map and state type of the remote update configuration control.
package ruc_pkg;

    localparam int CLK_FREQ_MHZ = 40;
    localparam int INIT_TIME_NS = 200;
    localparam int INIT_CYCLES  = (INIT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

    localparam int ADR_W = 4;
    localparam logic [ADR_W-1:0] ADR_CTRL   = 4'h0;
    localparam logic [ADR_W-1:0] ADR_CMD    = 4'h4;
    localparam logic [ADR_W-1:0] ADR_STATUS = 4'h8;

    localparam int PAGE_W = 3;
    localparam int TO_W   = 12;

    localparam int CTRL_PAGE_LSB = 0;
    localparam int CTRL_WDEN_BIT = 3;
    localparam int CTRL_TO_LSB   = 4;

    localparam int CMD_RECONF_BIT = 0;
    localparam int CMD_KICK_BIT   = 1;

    localparam int STAT_CAUSE_LSB  = 0;
    localparam int STAT_CLEAR_BIT  = 0;
    localparam int STAT_PAGE_LSB   = 2;
    localparam int STAT_APP_BIT    = 5;
    localparam int STAT_LOCAL_BIT  = 6;
    localparam int STAT_FAILED_LSB = 8;

    localparam logic [PAGE_W-1:0] FACTORY_PAGE  = 3'h0;
    localparam logic [PAGE_W-1:0] NEXT_PAGE_RST = 3'h1;
    localparam logic [TO_W-1:0]   WD_TO_RST     = 12'h100;

    localparam logic [1:0] CAUSE_NONE     = 2'h0;
    localparam logic [1:0] CAUSE_LOAD_ERR = 2'h1;
    localparam logic [1:0] CAUSE_WDOG     = 2'h2;

    typedef enum logic [2:0] {
        ST_WAIT_CE,
        ST_ARM,
        ST_LOAD,
        ST_INIT,
        ST_USER
    } ruc_state_e;

endpackage

// file: sim/ruc_mem_model.sv
// Behavioural paged configuration memory that answers load requests.
`timescale 1ns/1ps
`default_nettype none
module ruc_mem_model
(
    input  wire logic       ref_clk_i,
    input  wire logic       req_i,
    input  wire logic [2:0] page_i,
    input  wire logic [7:0] bad_i,
    input  wire logic [2:0] delay_i,
    output logic            done_o,
    output logic            err_o
);
    logic [2:0] cnt;

    initial
    begin
        done_o = 1'b0;
        err_o  = 1'b0;
        cnt    = 3'h0;
    end

    // Answers launch on the clock edge, like a synchronous memory.
    always @(posedge ref_clk_i)
    begin
        if (req_i !== 1'b1)
        begin
            done_o <= 1'b0;
            err_o  <= 1'b0;
            cnt    <= 3'h0;
        end
        else if (!done_o && !err_o)
        begin
            if (cnt < delay_i)
                cnt <= cnt + 3'h1;
            else if (bad_i[page_i] && page_i != 3'h0)
                err_o <= 1'b1;
            else
                done_o <= 1'b1;
        end
    end
endmodule // ruc_mem_model
`default_nettype wire

// file: sim/test_remote_update_config_control.sv
// Self-checking bench for the remote update configuration control.
`timescale 1ns/1ps
`default_nettype none
module test_remote_update_config_control;
    import ruc_pkg::*;
    localparam logic [2:0]  LP  = 3'h6;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic        clk, rst, cyc, stb, we, ce_n, lmode, done, err, ack, ce_out_n, req;
    logic        oe_n, urst, umode, app, req_q;
    logic [3:0]  adr, sel;
    logic [31:0] dat_w, dat_r;
    logic [2:0]  page, dly;
    logic [7:0]  bad;
    logic [63:0] e;
    logic [63:0] rd_q[$];
    logic [2:0]  pg_q[$];
    int          mismatches, n_compared;

    always #12.5 clk = ~clk;

    ruc_config_ctrl #(.LOCAL_PAGE(LP), .WD_PRESCALE(4)) i_dut (
        .ref_clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .chain_enable_in_n_i(ce_n), .chain_enable_out_n_o(ce_out_n), .local_mode_i(lmode),
        .load_done_i(done), .load_err_i(err), .load_req_o(req), .load_page_o(page),
        .user_io_oe_n_o(oe_n), .user_rst_o(urst), .user_mode_o(umode), .app_active_o(app));

    ruc_mem_model i_mem (.ref_clk_i(clk), .req_i(req), .page_i(page), .bad_i(bad),
        .delay_i(dly), .done_o(done), .err_o(err));

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Classic single Wishbone cycle; a read files its expected word and mask first.
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] x, input logic [31:0] m);
        int n;
        begin
            if (!w)
                rd_q.push_back({m, x});
            @(posedge clk);
            cyc   <= 1'b1;
            stb   <= 1'b1;
            we    <= w;
            adr   <= a;
            dat_w <= d;
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (ack !== 1'b1 && n < 50);
            if (n >= 50)
            begin
                check(1'b0, "bus answer missing");
                give_verdict();
            end
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask

    task automatic wait_on(input int w, output int n);
        begin
            n = 0;
            while (!(w == 0 ? urst === 1'b1 : umode === 1'b1) && n < 600)
            begin
                @(posedge clk);
                n++;
            end
            if (n >= 600)
            begin
                check(1'b0, "wait ran out");
                give_verdict();
            end
        end
    endtask

    // The second wait counts the cycles for which the initialization reset stands.
    task automatic wait_user;
        int n;
        begin
            wait_on(0, n);
            wait_on(1, n);
            @(posedge clk);
            check(oe_n === 1'b0 && ce_out_n === 1'b0, "pins after init");
            check(n == INIT_CYCLES && urst === 1'b0, "initialization reset length");
        end
    endtask

    // Scoreboard: read answers and load requests are matched to the oldest note.
    always @(posedge clk)
    begin
        req_q <= req;
        if (ack === 1'b1 && we === 1'b0)
        begin
            if (rd_q.size() == 0)
                check(1'b0, "unexpected read answer");
            else
            begin
                e = rd_q.pop_front();
                check(((dat_r ^ e[31:0]) & e[63:32]) === 32'h0, "read data");
            end
        end
        if (req === 1'b1 && req_q !== 1'b1)
        begin
            if (pg_q.size() == 0)
                check(1'b0, "unexpected load request");
            else
                check(page === pg_q.pop_front(), "load page");
        end
    end

    initial
    begin
        clk = 1'b0; rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0;
        sel = 4'hf; dat_w = 32'h0; ce_n = 1'b1; lmode = 1'b0; bad = 8'h20; dly = 3'h0;
        mismatches = 0;
        n_compared = 0;
        void'($urandom(32'hfb94f42f));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(oe_n === 1'b1 && ce_out_n === 1'b1 && req === 1'b0, "reset pins");
        pg_q.push_back(FACTORY_PAGE);
        ce_n <= 1'b0;
        wait_user();
        check(app === 1'b0, "factory flagged as application");
        wb(1'b0, ADR_CTRL, 0, {16'h0, WD_TO_RST, 1'b0, NEXT_PAGE_RST}, ALL);
        wb(1'b0, ADR_STATUS, 0, 32'h0, ALL);
        wb(1'b1, 4'hc, ALL, 0, 0);
        wb(1'b0, 4'hc, 0, 32'h0, ALL);
        wb(1'b0, ADR_CMD, 0, 32'h0, ALL);
        sel <= 4'h1;
        wb(1'b1, ADR_CTRL, 32'h0000_ab12, 0, 0);
        sel <= 4'hf;
        wb(1'b0, ADR_CTRL, 0, {16'h0, WD_TO_RST[TO_W-1:4], 4'h1, 1'b0, 3'h2}, ALL);
        $display("done: power-up and registers");
        wb(1'b1, ADR_CTRL, {16'h0, 12'h005, 1'b1, FACTORY_PAGE}, 0, 0);
        pg_q.push_back(FACTORY_PAGE);
        wb(1'b1, ADR_CMD, 32'h1, 0, 0);
        wait_user();
        repeat (100) @(posedge clk);
        check(req === 1'b0 && umode === 1'b1, "factory reloaded");
        wb(1'b1, ADR_CTRL, {16'h0, 12'h005, 1'b1, 3'h3}, 0, 0);
        pg_q.push_back(3'h3);
        wb(1'b1, ADR_CMD, 32'h1, 0, 0);
        wait_user();
        wb(1'b0, ADR_STATUS, 0, 32'h2c, ALL);
        repeat (10)
        begin
            repeat ($urandom_range(3, 8)) @(posedge clk);
            wb(1'b1, ADR_CMD, 32'h2, 0, 0);
        end
        check(req === 1'b0 && app === 1'b1, "watchdog fired despite kicks");
        pg_q.push_back(FACTORY_PAGE);
        wait_user();
        wb(1'b0, ADR_STATUS, 0, 32'h302, ALL);
        wb(1'b1, ADR_STATUS, 32'h1, 0, 0);
        wb(1'b0, ADR_STATUS, 0, 32'h0, 32'h3);
        $display("done: watchdog");
        wb(1'b1, ADR_CTRL, {16'h0, WD_TO_RST, 1'b0, 3'h5}, 0, 0);
        pg_q.push_back(3'h5);
        pg_q.push_back(FACTORY_PAGE);
        wb(1'b1, ADR_CMD, 32'h1, 0, 0);
        wait_user();
        wb(1'b0, ADR_STATUS, 0, 32'h501, ALL);
        $display("done: load error");
        bad <= 8'h00;
        for (int p = 1; p < 8; p++)
        begin
            dly <= 3'($urandom_range(0, 7));
            wb(1'b1, ADR_CTRL, {16'h0, WD_TO_RST, 1'b0, 3'(p)}, 0, 0);
            pg_q.push_back(3'(p));
            wb(1'b1, ADR_CMD, 32'h1, 0, 0);
            wait_user();
            wb(1'b0, ADR_STATUS, 0, {26'h0, 1'b1, 3'(p), 2'b00}, 32'h3c);
            pg_q.push_back(FACTORY_PAGE);
            wb(1'b1, ADR_CMD, 32'h1, 0, 0);
            wait_user();
        end
        $display("done: all application pages");
        rst   <= 1'b1;
        lmode <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        pg_q.push_back(LP);
        wait_user();
        wb(1'b0, ADR_STATUS, 0, {25'h0, 1'b1, 1'b1, LP, 2'b00}, ALL);
        pg_q.push_back(LP);
        wb(1'b1, ADR_CMD, 32'h1, 0, 0);
        wait_user();
        repeat (4) @(posedge clk);
        check(rd_q.size() == 0 && pg_q.size() == 0, "expectations left over");
        $display("done: local update");
        give_verdict();
    end
endmodule // test_remote_update_config_control
`default_nettype wire
